// ==== src/dco_defines.svh ====
// offsets, limits and timing counts for the disc command overlap block
`ifndef DCO_DEFINES_SVH
`define DCO_DEFINES_SVH
// address bytes in a full address
`define DCO_ADDR_BYTES 3'h5
// bytes one sector holds
`define DCO_SECTOR_BYTES 8'ha0
// first buffer index that lands on the stored address
`define DCO_DATA_LIMIT 8'hfb
// last usable buffer index
`define DCO_BUF_LAST 8'hff
// sectors on a track
`define DCO_SECTORS 8'h64
// address byte positions of track and sector
`define DCO_TRK_POS 3
`define DCO_SEC_POS 4
// sense bits
`define DCO_SNS_PARITY 2
`define DCO_SNS_FORMAT 7
// one disc revolution in ms and the clock in MHz
`define DCO_REV_MS 50
`define DCO_CLK_MHZ 50
`define DCO_REV_CYCLES (`DCO_REV_MS * 1000 * `DCO_CLK_MHZ)
`endif

// ==== src/dco_pkg.sv ====
// types for the disc command overlap block
package dco_pkg;
    typedef enum logic [2:0] {
        OP_SEEK = 3'h0,
        OP_SEARCH = 3'h1,
        OP_READ = 3'h2,
        OP_WRITE = 3'h3,
        OP_WRITE_CHK = 3'h4,
        OP_PREP = 3'h5,
        OP_SENSE = 3'h6,
        OP_OTHER = 3'h7
    } dco_op_e;
    // command as offered by the channel
    typedef struct packed {
        dco_op_e op;
        logic [1:0] unit;
        logic key_first;
    } dco_cmd_s;
    // command handed to the disc side
    typedef struct packed {
        dco_op_e op;
        logic [1:0] unit;
        logic [39:0] addr;
    } dco_exec_s;
endpackage

// ==== src/dco_buf_mem.sv ====
// byte buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module dco_buf_mem #(
    parameter int AW = 10
) (
    input wire logic clk, // system clock
    input wire logic wr_en, // write strobe
    input wire logic [AW-1:0] wr_addr, // write index
    input wire logic [7:0] wr_data, // write byte
    input wire logic [AW-1:0] rd_addr, // read index
    output logic [7:0] rd_data // byte, one cycle later
);
    logic [7:0] mem_q [0:(1<<AW)-1];
    // one write port, one registered read port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data <= mem_q[rd_addr];
    end
endmodule
`default_nettype wire

// ==== src/dco_ctrl.sv ====
// command sequencing, overlap and buffer handling for the disc control unit
`include "dco_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - format sense flag held during format write
// - same file moving: refuse only seeks
// - busy falling marks motion start
// - same file disc command buffered until motion ends
// - other file moving: refuse seek and search
// - no-motion command runs alongside the seek
// - motion command waits for earlier motion
// - short write address overlays stored address
// - illegal write address sets parity sense
// - short read address overlays stored address
// - short seek address gives no motion
// - only one sector of data is written
// - bytes past 251 overwrite stored address
// - write check adds one revolution
// - late key search adds one revolution
// - no arm delay when already on track
// - clear button clears latched errors
// - unit busy lamp while under control
// - file answers to its selector number
// - seek device end means motion began
module dco_ctrl #(
    parameter int NF = 2,
    parameter int REV_CYC = `DCO_REV_CYCLES,
    parameter logic [7:0] TRACKS = 8'hc8
) (
    input wire logic clk, // 50 MHz clock
    input wire logic rst, // sync reset, high
    input wire logic cmd_valid, // command offered
    input wire dco_pkg::dco_cmd_s cmd, // command fields
    output logic cmd_ready, // command taken
    output logic cmd_rej, // command refused
    input wire logic byte_valid, // byte offered
    input wire logic byte_is_addr, // byte is address
    input wire logic [7:0] byte_data, // byte value
    output logic byte_ready, // byte taken
    input wire logic cmd_end, // end of transfer
    input wire logic [NF-1:0] drv_busy, // file busy pin
    input wire logic [NF-1:0] drv_moving, // file motion pin
    input wire logic [2*NF-1:0] unit_sel, // selector switches
    input wire logic clr_btn, // clear pushbutton
    output logic [NF-1:0] seek_go, // start seek pulse
    output logic [7:0] seek_track, // seek target
    output logic dev_end, // device end pulse
    output logic exec_start, // command start pulse
    output dco_pkg::dco_exec_s exec_cmd, // running command
    output logic wr_valid, // write byte strobe
    output logic [7:0] wr_data, // write byte
    input wire logic rd_valid, // read byte strobe
    input wire logic [7:0] rd_data, // read byte
    output logic op_done, // command done pulse
    output logic [7:0] sense, // sense byte
    output logic format_mode, // format sense flag
    output logic [NF-1:0] unit_busy_led // busy lamps
);
    import dco_pkg::*;
    localparam int UW = (NF > 1) ? $clog2(NF) : 1;
    localparam int AW = UW + 8;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LOAD = 3'h1,
        ST_WAIT = 3'h2,
        ST_STREAM = 3'h3,
        ST_REV = 3'h4
    } dco_st_e;

    // =====================================================
    // input synchronisers
    logic [NF-1:0] busy_m, busy_s, busy_p, mov_m, mov_s;
    logic [2*NF-1:0] sel_m, sel_s;
    logic clr_m, clr_s;
    always_ff @(posedge clk) begin
        busy_m <= drv_busy;
        busy_s <= busy_m;
        busy_p <= busy_s; // delayed copy, finds the busy drop
        mov_m <= drv_moving;
        mov_s <= mov_m;
        sel_m <= unit_sel;
        sel_s <= sel_m;
        clr_m <= clr_btn;
        clr_s <= clr_m;
    end

    // =====================================================
    // state
    dco_st_e st_q;
    dco_cmd_s cur_q;
    logic [UW-1:0] ph_q;
    logic [2:0] acnt_q;
    logic [7:0] dcnt_q;
    logic dfull_q;
    logic [7:0] addr_q [NF][5];
    logic [7:0] trk_q [NF];
    logic [NF-1:0] sk_act_q, sk_seen_q;
    logic [7:0] scnt_q;
    logic [1:0] revs_q;
    logic [31:0] tmr_q;
    logic [7:0] sense_q;
    logic fmt_q;
    logic [7:0] mem_rd;

    // =====================================================
    // unit mapping, by selector switch rather than slot
    logic [NF-1:0] hit;
    logic map_ok;
    logic [UW-1:0] map_ph;
    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++) begin : g_map
            assign hit[gi] = (sel_s[2*gi +: 2] == cmd.unit);
        end
    endgenerate
    always_comb begin
        map_ok = 1'b0;
        map_ph = '0;
        for (int i = NF - 1; i >= 0; i--) begin
            if (hit[i]) begin
                map_ok = 1'b1;
                map_ph = UW'(i);
            end
        end
    end

    // =====================================================
    // seek tracking per file
    logic [NF-1:0] sk_start, sk_moving;
    generate
        for (gi = 0; gi < NF; gi++) begin : g_sk
            assign sk_start[gi] = sk_act_q[gi] & sk_seen_q[gi] & ~busy_s[gi];
            assign sk_moving[gi] = sk_start[gi];
        end
    endgenerate
    wire any_pre = |(sk_act_q & ~sk_start);
    wire any_mov = |sk_moving;

    // =====================================================
    // acceptance decode
    wire is_seek = (cmd.op == OP_SEEK);
    wire is_srch = (cmd.op == OP_SEARCH);
    // same file in motion: only seek refused
    wire rej_same = sk_moving[map_ph] & is_seek;
    // any other file in motion: seek and search refused
    wire rej_oth = |(sk_moving & ~hit) & (is_seek | is_srch);
    wire can_take = (st_q == ST_IDLE);
    wire refuse = ~map_ok | any_pre | rej_same | rej_oth;
    assign cmd_ready = can_take & cmd_valid & ~refuse;
    assign cmd_rej = can_take & cmd_valid & refuse;
    assign byte_ready = (st_q == ST_LOAD) & byte_valid;

    // =====================================================
    // address assembly and legality
    logic [39:0] addr_w;
    always_comb begin
        for (int b = 0; b < 5; b++) begin
            addr_w[8*b +: 8] = addr_q[ph_q][b];
        end
    end
    wire [7:0] tgt_trk = addr_q[ph_q][`DCO_TRK_POS];
    wire legal = (tgt_trk < TRACKS) & (addr_q[ph_q][`DCO_SEC_POS] < `DCO_SECTORS);
    // full address only after five bytes
    wire full_addr = (acnt_q == `DCO_ADDR_BYTES);
    wire cur_wr = (cur_q.op == OP_WRITE) | (cur_q.op == OP_WRITE_CHK);
    wire cur_rd = (cur_q.op == OP_READ);
    wire disc_op = cur_wr | cur_rd | (cur_q.op == OP_SEARCH);
    // no motion when head already on the track
    wire need_mov = disc_op & (tgt_trk != trk_q[ph_q]);
    // wait for own file; a command that needs motion waits for any motion
    wire must_wait = sk_moving[ph_q] | (need_mov & any_mov);
    wire [7:0] wr_len = dfull_q ? `DCO_SECTOR_BYTES :
        ((dcnt_q > `DCO_SECTOR_BYTES) ? `DCO_SECTOR_BYTES : dcnt_q);
    wire [1:0] rev_need = 2'h1 + {1'b0, cur_q.op == OP_WRITE_CHK}
        + {1'b0, (cur_q.op == OP_SEARCH) & ~cur_q.key_first};

    // =====================================================
    // buffer memory, one 256-byte page per file
    wire ld_data = byte_ready & ~byte_is_addr;
    wire ld_addr = byte_ready & byte_is_addr;
    // bytes at index 251 and up land on the address
    wire ld_ovl = ld_data & (dcnt_q >= `DCO_DATA_LIMIT) & ~dfull_q;
    wire [2:0] ovl_idx = 3'(dcnt_q - `DCO_DATA_LIMIT);
    wire rd_store = (st_q == ST_REV) & cur_rd & rd_valid;
    wire mem_we = (ld_data & (dcnt_q < `DCO_DATA_LIMIT)) | rd_store;
    wire [7:0] mem_wi = rd_store ? scnt_q : dcnt_q;
    dco_buf_mem #(.AW(AW)) i_dco_buf_mem (
        .clk(clk),
        .wr_en(mem_we),
        .wr_addr({ph_q, mem_wi}),
        .wr_data(rd_store ? rd_data : byte_data),
        .rd_addr({ph_q, scnt_q}),
        .rd_data(mem_rd)
    );

    // =====================================================
    // sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cur_q <= '0;
            ph_q <= '0;
            acnt_q <= 3'h0;
            dcnt_q <= 8'h00;
            dfull_q <= 1'b0;
            scnt_q <= 8'h00;
            revs_q <= 2'h0;
            tmr_q <= 32'h0;
            exec_cmd <= '0;
            exec_start <= 1'b0;
            op_done <= 1'b0;
            wr_valid <= 1'b0;
        end else begin
            exec_start <= 1'b0;
            op_done <= 1'b0;
            wr_valid <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (cmd_ready) begin
                        cur_q <= cmd;
                        ph_q <= map_ph;
                        acnt_q <= 3'h0;
                        dcnt_q <= 8'h00;
                        dfull_q <= 1'b0;
                        st_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (ld_addr && acnt_q != `DCO_ADDR_BYTES) begin
                        acnt_q <= acnt_q + 3'h1;
                    end
                    if (ld_data && !dfull_q) begin
                        dfull_q <= (dcnt_q == `DCO_BUF_LAST);
                        dcnt_q <= dcnt_q + 8'h01;
                    end
                    if (cmd_end) begin
                        if (cur_q.op == OP_SEEK || !disc_op) begin
                            op_done <= 1'b1;
                            st_q <= ST_IDLE;
                        end else begin
                            st_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    // runs at once when no motion conflict
                    if (!must_wait) begin
                        exec_start <= 1'b1;
                        scnt_q <= 8'h00;
                        revs_q <= rev_need;
                        tmr_q <= 32'h0;
                        exec_cmd <= '{cur_q.op, cur_q.unit, addr_w};
                        // illegal write address ends in error
                        if (cur_wr && !legal) begin
                            op_done <= 1'b1;
                            st_q <= ST_IDLE;
                        end else if (cur_wr && wr_len != 8'h00) begin
                            st_q <= ST_STREAM;
                        end else begin
                            st_q <= ST_REV;
                        end
                    end
                end
                ST_STREAM: begin
                    // strobe and byte leave their registers on the same edge
                    scnt_q <= scnt_q + 8'h01;
                    wr_valid <= 1'b1;
                    if (scnt_q == wr_len - 8'h01) begin
                        scnt_q <= 8'h00;
                        st_q <= ST_REV;
                    end
                end
                ST_REV: begin
                    if (rd_store && scnt_q != `DCO_SECTOR_BYTES) begin
                        scnt_q <= scnt_q + 8'h01;
                    end
                    if (tmr_q == 32'(REV_CYC - 1)) begin
                        tmr_q <= 32'h0;
                        revs_q <= revs_q - 2'h1;
                        if (revs_q == 2'h1) begin
                            op_done <= 1'b1;
                            st_q <= ST_IDLE;
                        end
                    end else begin
                        tmr_q <= tmr_q + 32'h1;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    assign wr_data = mem_rd;

    // =====================================================
    // stored address per file
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int f = 0; f < NF; f++) begin
                for (int b = 0; b < 5; b++) begin
                    addr_q[f][b] <= 8'h00;
                end
            end
        end else if (ld_addr && acnt_q != `DCO_ADDR_BYTES) begin
            // short address overlays the stored bytes
            addr_q[ph_q][acnt_q] <= byte_data;
        end else if (ld_ovl) begin
            addr_q[ph_q][ovl_idx] <= byte_data;
        end
    end

    // =====================================================
    // seek issue and motion tracking
    wire issue = (st_q == ST_LOAD) & cmd_end & (cur_q.op == OP_SEEK) & full_addr;
    always_ff @(posedge clk) begin
        if (rst) begin
            sk_act_q <= '0;
            sk_seen_q <= '0;
            seek_go <= '0;
            seek_track <= 8'h00;
            dev_end <= 1'b0;
            for (int f = 0; f < NF; f++) begin
                trk_q[f] <= 8'h00;
            end
        end else begin
            seek_go <= '0;
            // device end marks start of motion
            dev_end <= |(sk_start & busy_p);
            for (int f = 0; f < NF; f++) begin
                if (sk_act_q[f] && busy_s[f]) begin
                    sk_seen_q[f] <= 1'b1;
                end
                // motion ends once started and the motion pin drops
                if (sk_start[f] && !mov_s[f]) begin
                    sk_act_q[f] <= 1'b0;
                    sk_seen_q[f] <= 1'b0;
                end
            end
            // only a full address moves the arm
            if (issue) begin
                seek_go[ph_q] <= 1'b1;
                seek_track <= tgt_trk;
                sk_act_q[ph_q] <= 1'b1;
                sk_seen_q[ph_q] <= 1'b0;
                trk_q[ph_q] <= tgt_trk;
            end
        end
    end

    // =====================================================
    // sense byte and format flag
    wire new_cmd = cmd_ready & (cmd.op != OP_SENSE);
    wire par_err = (st_q == ST_WAIT) & ~must_wait & cur_wr & ~legal;
    always_ff @(posedge clk) begin
        if (rst) begin
            sense_q <= 8'h00;
            fmt_q <= 1'b0;
        end else begin
            // the error wins over any clear
            if (par_err) begin
                sense_q[`DCO_SNS_PARITY] <= 1'b1;
            end else if (new_cmd || clr_s) begin
                sense_q <= 8'h00;
            end
            // format flag follows the prep write mode
            if (cmd_ready) begin
                fmt_q <= (cmd.op == OP_PREP);
            end
        end
    end
    assign format_mode = fmt_q;
    assign sense = {fmt_q, sense_q[6:0]};

    // =====================================================
    // busy lamps
    generate
        for (gi = 0; gi < NF; gi++) begin : g_led
            // lit while the file is under control
            assign unit_busy_led[gi] = sk_act_q[gi] | ((st_q != ST_IDLE) & (ph_q == UW'(gi)));
        end
    endgenerate
endmodule
`default_nettype wire

// ==== tb/dco_disc_model.sv ====
// disc file model: busy, then motion, after each seek pulse; read bytes stream
`timescale 1ns/1ps
`default_nettype none
module dco_disc_model #(
    parameter int NF = 2,
    parameter int BSY = 6,
    parameter int MOV = 200
) (
    input wire logic clk, // system clock
    input wire logic [NF-1:0] seek_go, // seek pulse
    output logic [NF-1:0] drv_busy, // busy pin
    output logic [NF-1:0] drv_moving, // motion pin
    output logic rd_valid, // read byte strobe
    output logic [7:0] rd_data // read byte, changes every cycle
);
    int cnt [NF];
    logic [7:0] rd_q = 8'h00;
    // =====
    // counters move just after the edge, like any other driver
    always @(posedge clk) begin
        #1;
        for (int f = 0; f < NF; f++) begin
            if (seek_go[f]) cnt[f] = BSY + MOV;
            else if (cnt[f] > 0) cnt[f] = cnt[f] - 1;
        end
        rd_q = rd_q + 8'h01;
    end
    always_comb begin
        for (int f = 0; f < NF; f++) begin
            drv_busy[f] = cnt[f] > MOV;
            drv_moving[f] = cnt[f] > 0 && cnt[f] <= MOV;
        end
    end
    assign rd_valid = rd_q[1:0] == 2'h0;
    assign rd_data = rd_q;
endmodule
`default_nettype wire

// ==== tb/dco_ctrl_properties.sv ====
// property checker for the disc command overlap block
`timescale 1ns/1ps
`default_nettype none
module dco_ctrl_chk import dco_pkg::*; #(
    parameter int NF = 2
) (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic cmd_valid, // command offered
    input wire dco_pkg::dco_cmd_s cmd, // command fields
    input wire logic cmd_ready, // command taken
    input wire logic cmd_end, // end of transfer
    input wire logic [NF-1:0] drv_moving, // motion pins
    input wire logic [2*NF-1:0] unit_sel, // selectors
    input wire logic clr_btn, // clear button
    input wire logic [NF-1:0] seek_go, // seek pulse
    input wire logic dev_end, // device end
    input wire logic exec_start, // start pulse
    input wire logic wr_valid, // write strobe
    input wire logic op_done, // done pulse
    input wire logic [7:0] sense, // sense byte
    input wire logic format_mode, // format flag
    input wire logic [NF-1:0] unit_busy_led // lamps
);
    logic [NF-1:0] mv1_q, mv2_q, mv3_q, tgt;
    logic [3:0] ev_q;
    logic [8:0] wr_cnt_q;
    wire taken = cmd_valid && cmd_ready;
    // motion seen on four samples, so the synchroniser lag is covered
    wire [NF-1:0] mv_hold = drv_moving & mv1_q & mv2_q & mv3_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // =====
    // file addressed by the offered unit
    always_comb begin
        for (int f = 0; f < NF; f++) tgt[f] = unit_sel[2*f +: 2] == cmd.unit;
    end
    // history and per-command byte count
    always_ff @(posedge clk) begin
        mv1_q <= drv_moving;
        mv2_q <= mv1_q;
        mv3_q <= mv2_q;
        ev_q <= {ev_q[2:0], taken || op_done};
        if (rst || exec_start) wr_cnt_q <= 9'h000;
        else if (wr_valid) wr_cnt_q <= wr_cnt_q + 9'h001;
    end
    seek_refused_a: assert property (cmd_valid && cmd.op == OP_SEEK && |mv_hold |-> !cmd_ready)
        else $error("seek taken while a file moves");
    search_refused_a: assert property (cmd_valid && cmd.op == OP_SEARCH && |(mv_hold & ~tgt)
        |-> !cmd_ready) else $error("search taken while another file moves");
    busy_first_a: assert property (|seek_go |=> !dev_end [*4])
        else $error("device end before busy dropped");
    seek_at_end_a: assert property (|seek_go |-> $past(cmd_end))
        else $error("seek pulse without end of transfer");
    lamp_on_a: assert property (|seek_go |-> (unit_busy_led & seek_go) == seek_go)
        else $error("busy lamp dark on seeking file");
    sector_limit_a: assert property (wr_valid |-> wr_cnt_q < 9'h0a0)
        else $error("more than one sector written");
    clear_parity_a: assert property (clr_btn [*6] |-> !sense[2])
        else $error("parity kept during clear");
    format_hold_a: assert property ($fell(format_mode) |-> |ev_q || taken)
        else $error("format flag dropped with no command");
    cover property (|seek_go);
    cover property ($rose(sense[2]));
    cover property (taken && cmd.op == OP_PREP);
endmodule
bind dco_ctrl dco_ctrl_chk #(.NF(NF)) i_dco_ctrl_chk (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .cmd_end(cmd_end),
    .drv_moving(drv_moving), .unit_sel(unit_sel), .clr_btn(clr_btn), .seek_go(seek_go),
    .dev_end(dev_end), .exec_start(exec_start), .wr_valid(wr_valid), .op_done(op_done),
    .sense(sense), .format_mode(format_mode), .unit_busy_led(unit_busy_led));
`default_nettype wire

// ==== tb/disc_control_command_overlap_tb_top.sv ====
// self-checking bench for the disc command overlap block
`timescale 1ns/1ps
`default_nettype none
module disc_control_command_overlap_tb_top;
    import dco_pkg::*;
    localparam int REV = 20;
    logic clk = 0, rst = 1, cmd_valid = 0, byte_valid = 0, byte_is_addr = 0, cmd_end = 0;
    logic clr_btn = 0, ok, rj, ex_mv;
    logic [7:0] byte_data = 8'h00, ov_trk = 8'h00, ov_sec = 8'h00;
    dco_cmd_s cmd = '0;
    logic [3:0] unit_sel = 4'h6; // file0 answers unit 2, file1 unit 1
    logic cmd_ready, cmd_rej, byte_ready, dev_end, exec_start, wr_valid, rd_valid, op_done;
    logic format_mode;
    dco_exec_s ex_cmd, ex_seen;
    logic [7:0] wr_first, wr_last;
    logic [1:0] drv_busy, drv_moving, seek_go, unit_busy_led, go_seen = 2'h0;
    logic [7:0] seek_track, wr_data, rd_data, sense;
    int err_total = 0, cmp_count = 0, wr_seen = 0, n1 = 0, n2 = 0;
    dco_ctrl #(.NF(2), .REV_CYC(REV)) i_dco_ctrl (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .cmd_rej(cmd_rej), .byte_valid(byte_valid),
        .byte_is_addr(byte_is_addr), .byte_data(byte_data), .byte_ready(byte_ready),
        .cmd_end(cmd_end), .drv_busy(drv_busy), .drv_moving(drv_moving), .unit_sel(unit_sel),
        .clr_btn(clr_btn), .seek_go(seek_go), .seek_track(seek_track), .dev_end(dev_end),
        .exec_start(exec_start), .exec_cmd(ex_cmd), .wr_valid(wr_valid), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_data(rd_data), .op_done(op_done), .sense(sense),
        .format_mode(format_mode), .unit_busy_led(unit_busy_led));
    dco_disc_model #(.NF(2)) i_dco_disc_model (.clk(clk), .seek_go(seek_go),
        .drv_busy(drv_busy), .drv_moving(drv_moving), .rd_valid(rd_valid), .rd_data(rd_data));
    // =====
    always #10 clk = ~clk;
    // seek pulses and written bytes since last cleared, and the last started command
    always @(posedge clk) begin
        go_seen = go_seen | seek_go;
        if (wr_valid === 1'b1) begin
            if (wr_seen == 0) wr_first = wr_data;
            wr_last = wr_data;
            wr_seen++;
        end
        if (exec_start === 1'b1) ex_seen = ex_cmd;
    end
    task automatic end_of_test;
        if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask
    // inputs always move one ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic issue(input dco_op_e op, input logic [1:0] u, input logic k);
        cmd_valid = 1;
        cmd = '{op, u, k};
        #1;
        ok = cmd_ready;
        rj = cmd_rej;
        cyc(1);
        cmd_valid = 0;
    endtask
    task automatic put(input logic a, input logic [7:0] d);
        byte_valid = 1;
        byte_is_addr = a;
        byte_data = d;
        // ready is looked at on the edge itself, before the design moves
        do @(posedge clk); while (byte_ready !== 1'b1);
        #1;
    endtask
    // cycles from end of transfer to done; notes motion at start
    task automatic done(output int n);
        n = 0;
        ex_mv = 1'bx;
        while (op_done !== 1'b1 && n < 3000) begin
            if (exec_start === 1'b1) ex_mv = |drv_moving;
            cyc(1);
            n++;
        end
        if (n == 3000) chk(0, 1);
        cyc(1);
    endtask
    // address bytes 3 and 4 carry track and sector
    task automatic run(input dco_op_e op, input logic [1:0] u, input logic k, input int na,
        input int nd, input logic [7:0] trk, input logic [7:0] sec, output int n);
        issue(op, u, k);
        wr_seen = 0;
        go_seen = 0;
        for (int i = 0; i < na; i++) put(1'b1, i == 3 ? trk : i == 4 ? sec : 8'h00);
        for (int j = 0; j < nd; j++) put(1'b0, j == 254 ? ov_trk : j == 255 ? ov_sec : j[7:0]);
        byte_valid = 0;
        cmd_end = 1;
        cyc(1);
        cmd_end = 0;
        done(n);
    endtask
    task automatic devw;
        int k = 0;
        while (dev_end !== 1'b1 && k < 100) begin
            cyc(1);
            k++;
        end
        chk(k < 100, 1);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_of_test;
    end
    // =====
    initial begin
        cyc(12);
        rst = 0;
        cyc(3);
        run(OP_SEEK, 2'h2, 1'b1, 4, 0, 8'h05, 8'h00, n1);
        chk(go_seen, 2'b00);
        run(OP_SEEK, 2'h2, 1'b1, 5, 0, 8'h05, 8'h00, n1);
        chk(go_seen, 2'b01);
        chk(seek_track, 8'h05);
        devw;
        chk(drv_busy, 2'b00);
        chk(unit_busy_led, 2'b01);
        issue(OP_SEEK, 2'h2, 1'b1);
        chk({ok, rj}, 2'b01);
        issue(OP_SEARCH, 2'h1, 1'b1);
        chk({ok, rj}, 2'b01);
        run(OP_WRITE, 2'h2, 1'b1, 5, 4, 8'h05, 8'h03, n1);
        chk(ex_mv, 1'b0);
        while (drv_moving !== 2'b00) cyc(1);
        cyc(4);
        run(OP_WRITE, 2'h2, 1'b1, 5, 170, 8'h05, 8'h01, n1);
        chk(wr_seen, 160);
        chk({wr_first, wr_last}, 16'h009f);
        run(OP_WRITE_CHK, 2'h2, 1'b1, 5, 170, 8'h05, 8'h01, n2);
        chk(n2 - n1, REV);
        run(OP_SEARCH, 2'h2, 1'b1, 5, 2, 8'h05, 8'h01, n1);
        run(OP_SEARCH, 2'h2, 1'b0, 5, 2, 8'h05, 8'h01, n2);
        chk(n2 - n1, REV);
        ov_trk = 8'hc8;
        ov_sec = 8'h01;
        run(OP_WRITE, 2'h2, 1'b1, 5, 256, 8'h05, 8'h01, n1);
        chk(sense[2], 1'b1);
        chk(wr_seen, 0);
        clr_btn = 1;
        cyc(8);
        clr_btn = 0;
        cyc(4);
        chk(sense[2], 1'b0);
        ov_trk = 8'h07;
        run(OP_WRITE, 2'h2, 1'b1, 5, 256, 8'h05, 8'h01, n1);
        chk({sense[2], wr_seen[7:0]}, {1'b0, 8'ha0});
        run(OP_WRITE, 2'h2, 1'b1, 3, 3, 8'h00, 8'h00, n1);
        chk({sense[2], wr_seen[7:0]}, {1'b0, 8'h03});
        chk(ex_seen.addr[39:24], 16'h0107);
        run(OP_READ, 2'h2, 1'b1, 2, 0, 8'h00, 8'h00, n1);
        chk(sense[2], 1'b0);
        chk(ex_seen.addr[39:24], 16'h0107);
        run(OP_WRITE, 2'h2, 1'b1, 4, 3, 8'hd0, 8'h00, n1);
        chk(sense[2], 1'b1);
        run(OP_SEEK, 2'h1, 1'b1, 5, 0, 8'h09, 8'h00, n1);
        chk(go_seen, 2'b10);
        devw;
        run(OP_PREP, 2'h2, 1'b1, 0, 0, 8'h00, 8'h00, n1);
        chk(drv_moving[1], 1'b1);
        chk(format_mode, 1'b1);
        run(OP_READ, 2'h2, 1'b1, 5, 0, 8'h05, 8'h00, n1);
        chk(ex_mv, 1'b1);
        chk(format_mode, 1'b0);
        run(OP_READ, 2'h2, 1'b1, 5, 0, 8'h09, 8'h00, n1);
        chk(ex_mv, 1'b0);
        end_of_test;
    end
endmodule
`default_nettype wire
